// File: hdl/sgc_pkg.sv
// Constants, register map and types of the switch global config bank
package sgc_pkg;
  // Clock rate and storm-limiting periods
  localparam int unsigned CLK_KHZ = 125000;
  localparam int unsigned PERIOD_FAST_MS = 67;
  localparam int unsigned PERIOD_SLOW_MS = 500;
  localparam int unsigned PERIOD_FAST_CYC = PERIOD_FAST_MS * CLK_KHZ;
  localparam int unsigned PERIOD_SLOW_CYC = PERIOD_SLOW_MS * CLK_KHZ;
  localparam int unsigned PERIOD_CNT_W = 26;

  // Bus widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 8;
  localparam int unsigned RATE_W = 11;
  localparam int unsigned RATE_HI_W = 3;
  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned IDX_W = 4;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_STORM_RATE_LOW = 4'h7;
  localparam logic [IDX_W-1:0] IDX_FACTORY_TEST_A = 4'h8;
  localparam logic [IDX_W-1:0] IDX_FACTORY_TEST_B = 4'h9;
  localparam logic [IDX_W-1:0] IDX_FACTORY_TEST_C = 4'hA;
  localparam logic [IDX_W-1:0] IDX_LED_LOOPBACK = 4'hB;
  localparam logic [IDX_W-1:0] IDX_PRIO_MAP_LOW = 4'hC;
  localparam logic [IDX_W-1:0] IDX_PRIO_MAP_HIGH = 4'hD;

  // Reset values
  localparam logic [REG_W-1:0] RST_STORM_RATE_LOW = 8'h63;
  localparam logic [REG_W-1:0] RST_FACTORY_TEST_A = 8'h00;
  localparam logic [REG_W-1:0] RST_FACTORY_TEST_B = 8'h24;
  localparam logic [REG_W-1:0] RST_FACTORY_TEST_C = 8'h35;
  localparam logic [REG_W-1:0] RST_LED_LOOPBACK_FIXED = 8'h08;
  localparam logic [REG_W-1:0] RST_PRIO_MAP_LOW = 8'h50;
  localparam logic [REG_W-1:0] RST_PRIO_MAP_HIGH = 8'hFA;

  // Bit positions in led_loopback_control
  localparam int unsigned BIT_LED_MODE_SEL_HI = 7;
  localparam int unsigned BIT_ERROR_DROP = 5;
  localparam int unsigned BIT_TEST_MODE = 4;
  localparam int unsigned BIT_LOOP_POSITION_HI = 3;
  localparam int unsigned BIT_LOOP_POSITION_LO = 2;
  localparam int unsigned BIT_LED_MODE_SEL_LO = 1;
  localparam int unsigned BIT_DIRECT_FORWARD_TAG = 0;

  // Priority map layout
  localparam int unsigned PRIO_W = 2;
  localparam int unsigned PCP_W = 3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SGC_SITE_COPPER,
    SGC_SITE_MAC,
    SGC_SITE_OPTICAL
  } sgc_loop_site_t;
endpackage

// File: hdl/sgc_frame_policy.sv
// Per-frame loopback drop decision and 802.1p priority class lookup
`timescale 1ns/10ps
`default_nettype none
module sgc_frame_policy
  import sgc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic error_drop,
  input wire logic [2*REG_W-1:0] prio_map,
  input wire logic frame_done,
  input wire logic frame_oam,
  input wire logic frame_error,
  input wire logic tag_valid,
  input wire logic [PCP_W-1:0] tag_pcp,
  output logic loop_keep,
  output logic loop_drop,
  output logic prio_valid,
  output logic [PRIO_W-1:0] prio_class
);

  // OAM never loops back; errored frames only when dropping is on
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      loop_keep <= 1'b0;
      loop_drop <= 1'b0;
    end else begin
      loop_drop <= frame_done & (frame_oam | (frame_error & error_drop));
      loop_keep <= frame_done & ~frame_oam & ~(frame_error & error_drop);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prio_valid <= 1'b0;
      prio_class <= '0;
    end else begin
      prio_valid <= tag_valid;
      if (tag_valid) begin
        prio_class <= prio_map[tag_pcp*PRIO_W +: PRIO_W];
      end
    end
  end

  drop_policy_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    frame_done |=> loop_drop == ($past(frame_oam) |
      ($past(frame_error) & $past(error_drop))) && (loop_keep != loop_drop))
    else $error("loopback drop decision wrong");

  prio_lookup_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tag_valid |=> prio_valid &&
      prio_class == $past(prio_map[tag_pcp*PRIO_W +: PRIO_W]))
    else $error("priority class does not follow map");

endmodule
`default_nettype wire

// File: hdl/sgc_regs.sv
// Global configuration register bank with AXI4-Lite slave
//
// Overview of operation
// - Low byte forms storm count bits 7-0
// - Count bits 10-8 from preceding register
// - Period 67 ms fast, 500 ms slow
// - Storm rate low resets to 0x63
// - LED mode from control bits 7 and 1
// - LED select bits load from straps
// - Error-drop set: drop OAM and bad frames
// - Error-drop clear: drop OAM frames only
// - Loop position: copper, MAC, or optical
// - Low position bit overrides high bit
// - Error-drop bit resets from its strap
// - Bit 0 enables direct-forward tag mode
// - Tag value selects two-bit priority class
// - Map registers hold tags 0-3, 4-7
// - Map reset: 00,00,01,01,10,10,11,11
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module sgc_regs
  import sgc_pkg::*;
#(
  parameter int unsigned PERIOD_FAST = PERIOD_FAST_CYC,
  parameter int unsigned PERIOD_SLOW = PERIOD_SLOW_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [DATA_W/8-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Strap pins, sampled while reset is held
  input wire logic led_mode_sel_hi_strap,
  input wire logic led_mode_sel_lo_strap,
  input wire logic error_drop_strap,
  input wire logic loop_position_strap,
  // Upper storm-rate bits from the preceding register
  input wire logic [RATE_HI_W-1:0] storm_rate_high,
  input wire logic port_speed_100,
  // Frame side
  input wire logic frame_done,
  input wire logic frame_oam,
  input wire logic frame_error,
  input wire logic tag_valid,
  input wire logic [PCP_W-1:0] tag_pcp,
  // Configuration outputs
  output logic [RATE_W-1:0] storm_rate_count,
  output logic storm_period_tick,
  output logic [1:0] led_mode_sel,
  output logic test_mode,
  output sgc_loop_site_t loop_site,
  output logic error_drop,
  output logic direct_forward_tag_mode,
  output logic loop_keep,
  output logic loop_drop,
  output logic prio_valid,
  output logic [PRIO_W-1:0] prio_class
);

  logic [REG_W-1:0] storm_rate_low;
  logic [REG_W-1:0] factory_test_a;
  logic [REG_W-1:0] factory_test_b;
  logic [REG_W-1:0] factory_test_c;
  logic [REG_W-1:0] led_loopback_control;
  logic [REG_W-1:0] priority_map_low_tags;
  logic [REG_W-1:0] priority_map_high_tags;
  logic [ADDR_W-1:0] wr_addr;
  logic [REG_W-1:0] wr_data;
  logic wr_strb;
  logic wr_fire;
  logic [PERIOD_CNT_W-1:0] period_cnt;
  logic [PERIOD_CNT_W-1:0] period_limit;
  logic speed_prev;

  function automatic logic [IDX_W-1:0] addr_index(
    input logic [ADDR_W-1:0] a
  );
    return a[IDX_LSB +: IDX_W];
  endfunction

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    logic [IDX_W-1:0] idx;
    idx = addr_index(a);
    return (a[IDX_LSB-1:0] == '0) && (a[ADDR_W-1:IDX_LSB+IDX_W] == '0) &&
      (idx >= IDX_STORM_RATE_LOW) && (idx <= IDX_PRIO_MAP_HIGH);
  endfunction

  function automatic logic wr_to(input logic [IDX_W-1:0] idx);
    return wr_fire && wr_strb && addr_hit(wr_addr) &&
      (addr_index(wr_addr) == idx);
  endfunction

  // Write channel: address and data taken in either order
  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        wr_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wr_data <= s_axi_wdata[REG_W-1:0];
        wr_strb <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_hit(wr_addr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read channel: data straight from the live registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        case (addr_index(s_axi_araddr))
          IDX_STORM_RATE_LOW: s_axi_rdata <= DATA_W'(storm_rate_low);
          IDX_FACTORY_TEST_A: s_axi_rdata <= DATA_W'(factory_test_a);
          IDX_FACTORY_TEST_B: s_axi_rdata <= DATA_W'(factory_test_b);
          IDX_FACTORY_TEST_C: s_axi_rdata <= DATA_W'(factory_test_c);
          IDX_LED_LOOPBACK: s_axi_rdata <= DATA_W'(led_loopback_control);
          IDX_PRIO_MAP_LOW: s_axi_rdata <= DATA_W'(priority_map_low_tags);
          IDX_PRIO_MAP_HIGH: s_axi_rdata <= DATA_W'(priority_map_high_tags);
          default: s_axi_rdata <= '0;
        endcase
        if (!addr_hit(s_axi_araddr)) begin
          s_axi_rdata <= '0;
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Storm rate and factory test registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      storm_rate_low <= RST_STORM_RATE_LOW;
      factory_test_a <= RST_FACTORY_TEST_A;
      factory_test_b <= RST_FACTORY_TEST_B;
      factory_test_c <= RST_FACTORY_TEST_C;
    end else begin
      if (wr_to(IDX_STORM_RATE_LOW)) begin
        storm_rate_low <= wr_data;
      end
      // Kept only as storage; writes are accepted though discouraged
      if (wr_to(IDX_FACTORY_TEST_A)) begin
        factory_test_a <= wr_data;
      end
      if (wr_to(IDX_FACTORY_TEST_B)) begin
        factory_test_b <= wr_data;
      end
      if (wr_to(IDX_FACTORY_TEST_C)) begin
        factory_test_c <= wr_data;
      end
    end
  end

  // LED and loopback control; reset is synchronous so straps are legal
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      led_loopback_control <= RST_LED_LOOPBACK_FIXED;
      led_loopback_control[BIT_LED_MODE_SEL_HI] <= led_mode_sel_hi_strap;
      led_loopback_control[BIT_LED_MODE_SEL_LO] <= led_mode_sel_lo_strap;
      led_loopback_control[BIT_ERROR_DROP] <= error_drop_strap;
      led_loopback_control[BIT_LOOP_POSITION_LO] <= loop_position_strap;
    end else if (wr_to(IDX_LED_LOOPBACK)) begin
      led_loopback_control <= wr_data;
    end
  end

  // Priority maps
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      priority_map_low_tags <= RST_PRIO_MAP_LOW;
      priority_map_high_tags <= RST_PRIO_MAP_HIGH;
    end else begin
      if (wr_to(IDX_PRIO_MAP_LOW)) begin
        priority_map_low_tags <= wr_data;
      end
      if (wr_to(IDX_PRIO_MAP_HIGH)) begin
        priority_map_high_tags <= wr_data;
      end
    end
  end

  assign led_mode_sel = {led_loopback_control[BIT_LED_MODE_SEL_HI],
    led_loopback_control[BIT_LED_MODE_SEL_LO]};
  assign error_drop = led_loopback_control[BIT_ERROR_DROP];
  // Exposed so the test logic outside can honour it
  assign test_mode = led_loopback_control[BIT_TEST_MODE];
  assign direct_forward_tag_mode =
    led_loopback_control[BIT_DIRECT_FORWARD_TAG];

  // Decoded loopback site lags the register by one cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      loop_site <= SGC_SITE_MAC;
    end else if (led_loopback_control[BIT_LOOP_POSITION_LO]) begin
      loop_site <= SGC_SITE_OPTICAL;
    end else if (led_loopback_control[BIT_LOOP_POSITION_HI]) begin
      loop_site <= SGC_SITE_MAC;
    end else begin
      loop_site <= SGC_SITE_COPPER;
    end
  end

  // Storm budget count
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      storm_rate_count <= '0;
    end else begin
      storm_rate_count <= {storm_rate_high, storm_rate_low};
    end
  end

  // Limiting period; a speed change restarts it
  assign period_limit = port_speed_100 ?
    PERIOD_CNT_W'(PERIOD_FAST - 1) : PERIOD_CNT_W'(PERIOD_SLOW - 1);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      period_cnt <= '0;
      speed_prev <= 1'b0;
      storm_period_tick <= 1'b0;
    end else begin
      speed_prev <= port_speed_100;
      storm_period_tick <= (period_cnt == period_limit) &&
        (speed_prev == port_speed_100);
      if ((period_cnt == period_limit) || (speed_prev != port_speed_100)) begin
        period_cnt <= '0;
      end else begin
        period_cnt <= period_cnt + 1'b1;
      end
    end
  end

  sgc_frame_policy u_policy (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .error_drop(error_drop),
    .prio_map({priority_map_high_tags, priority_map_low_tags}),
    .frame_done(frame_done),
    .frame_oam(frame_oam),
    .frame_error(frame_error),
    .tag_valid(tag_valid),
    .tag_pcp(tag_pcp),
    .loop_keep(loop_keep),
    .loop_drop(loop_drop),
    .prio_valid(prio_valid),
    .prio_class(prio_class)
  );

  storm_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(rst_n) |-> storm_rate_low == RST_STORM_RATE_LOW &&
      factory_test_b == RST_FACTORY_TEST_B)
    else $error("storm rate low reset value wrong");

  rate_compose_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(rst_n) ##1 1'b1 |-> storm_rate_count ==
      {$past(storm_rate_high), $past(storm_rate_low)})
    else $error("storm count not composed from both registers");

  rate_follow_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $stable(storm_rate_high) && $stable(storm_rate_low) |=>
      storm_rate_count[RATE_W-1:REG_W] == $past(storm_rate_high, 2))
    else $error("storm count high bits wrong");

  period_tick_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    storm_period_tick |-> $past(period_cnt) == $past(period_limit) &&
      period_cnt == '0)
    else $error("storm period tick at wrong count");

  strap_load_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(rst_n) |-> led_mode_sel ==
      {$past(led_mode_sel_hi_strap), $past(led_mode_sel_lo_strap)} &&
      error_drop == $past(error_drop_strap))
    else $error("strap values not loaded at reset");

  loop_site_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    led_loopback_control[BIT_LOOP_POSITION_LO] |=>
      loop_site == SGC_SITE_OPTICAL)
    else $error("low position bit does not select optical");

  tag_mode_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(rst_n) |-> !direct_forward_tag_mode && !test_mode)
    else $error("tag mode or test bit not cleared at reset");

  prio_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(rst_n) |-> priority_map_low_tags == RST_PRIO_MAP_LOW &&
      priority_map_high_tags == RST_PRIO_MAP_HIGH)
    else $error("priority map reset wrong");

  write_apply_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_fire && wr_strb && addr_hit(wr_addr) &&
      addr_index(wr_addr) == IDX_LED_LOOPBACK |=>
      led_loopback_control == $past(wr_data) &&
      direct_forward_tag_mode == $past(wr_data[BIT_DIRECT_FORWARD_TAG]))
    else $error("register write not applied next cycle");

endmodule
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking testbench of the switch global config register bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import sgc_pkg::*;
  logic clk_sys = 1'b0, rst_n = 1'b0, port_speed_100 = 1'b1;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, tag_valid = 1'b0;
  logic led_mode_sel_hi_strap = 1'b0, led_mode_sel_lo_strap = 1'b0;
  logic error_drop_strap = 1'b0, loop_position_strap = 1'b0;
  logic frame_done = 1'b0, frame_oam = 1'b0, frame_error = 1'b0;
  logic [RATE_HI_W-1:0] storm_rate_high = '0;
  logic [PCP_W-1:0] tag_pcp = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, storm_period_tick, test_mode, error_drop;
  logic direct_forward_tag_mode, loop_keep, loop_drop, prio_valid;
  logic [1:0] s_axi_bresp, s_axi_rresp, led_mode_sel, prio_class, resp;
  logic [RATE_W-1:0] storm_rate_count;
  sgc_loop_site_t loop_site;
  int mismatches = 0, n_checks = 0, seed = 59291, mdl [16];
  logic [7:0] bad [4] = '{8'h00, 8'h1D, 8'h38, 8'hFC};

  always #4 clk_sys = ~clk_sys;

  sgc_regs #(.PERIOD_FAST(20), .PERIOD_SLOW(50)) u_sgc_regs (
    .clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .led_mode_sel_hi_strap,
    .led_mode_sel_lo_strap, .error_drop_strap, .loop_position_strap,
    .storm_rate_high, .port_speed_100, .frame_done, .frame_oam,
    .frame_error, .tag_valid, .tag_pcp, .storm_rate_count,
    .storm_period_tick, .led_mode_sel, .test_mode, .loop_site,
    .error_drop, .direct_forward_tag_mode, .loop_keep, .loop_drop,
    .prio_valid, .prio_class
  );

  task automatic end_of_test();
    if (mismatches == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic hang(input string what);
    mismatches++;
    $display("mismatch at %0t: %s timed out", $time, what);
    end_of_test();
  endtask

  task automatic axi(input bit wr, input logic [7:0] a,
                     input logic [7:0] d = 8'h00, input logic st = 1'b0);
    bit got = 0;
    @(posedge clk_sys);
    if (wr) begin
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= DATA_W'(d);
      s_axi_wstrb <= {4{st}};
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    for (int n = 0; n < 50 && !got; n++) begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_bready && s_axi_bvalid) begin
        got = 1;
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
      if (s_axi_rready && s_axi_rvalid) begin
        got = 1;
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
    if (!got) hang("bus");
  endtask

  task automatic wreg(input int i, input logic [7:0] d);
    axi(1'b1, 8'(i * 4), d, 1'b1);
    chk(resp, RESP_OKAY, "bresp");
    mdl[i] = d;
  endtask

  task automatic rreg(input int i);
    axi(1'b0, 8'(i * 4));
    chk(resp, RESP_OKAY, "rresp");
    chk(rd, mdl[i], "rdata");
  endtask

  task automatic do_reset();
    logic [3:0] s;
    s = 4'($random(seed));
    @(posedge clk_sys);
    rst_n <= 1'b0;
    {led_mode_sel_hi_strap, led_mode_sel_lo_strap, error_drop_strap,
     loop_position_strap} <= s;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    // Straps flipped after release must not reach the registers
    {led_mode_sel_hi_strap, led_mode_sel_lo_strap, error_drop_strap,
     loop_position_strap} <= ~s;
    mdl[7] = 8'h63;
    mdl[8] = 8'h00;
    mdl[9] = 8'h24;
    mdl[10] = 8'h35;
    mdl[11] = {s[3], 1'b0, s[1], 1'b0, 1'b1, s[0], s[2], 1'b0};
    mdl[12] = 8'h50;
    mdl[13] = 8'hFA;
  endtask

  task automatic outs();
    logic [7:0] c;
    sgc_loop_site_t s;
    c = 8'(mdl[11]);
    s = c[2] ? SGC_SITE_OPTICAL : (c[3] ? SGC_SITE_MAC : SGC_SITE_COPPER);
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(led_mode_sel, {c[7], c[1]}, "led");
    chk(error_drop, c[5], "edrop");
    chk(test_mode, c[4], "test");
    chk(direct_forward_tag_mode, c[0], "dfwd");
    chk(loop_site, s, "site");
    chk(storm_rate_count, {storm_rate_high, mdl[7][7:0]}, "rate");
  endtask

  task automatic policy();
    logic kd = 0, dd = 0, pv = 0, have = 0, f, o, e, t;
    logic [1:0] pc;
    logic [2:0] p;
    for (int i = 0; i <= 40; i++) begin
      {f, o, e, t} = (i == 40) ? 4'h0 : 4'($random(seed));
      p = 3'($random(seed));
      @(posedge clk_sys);
      frame_done <= f;
      frame_oam <= o;
      frame_error <= e;
      tag_valid <= t;
      tag_pcp <= p;
      @(negedge clk_sys);
      chk(loop_keep, kd, "keep");
      chk(loop_drop, dd, "ldrop");
      chk(prio_valid, pv, "pvalid");
      if (have) chk(prio_class, pc, "class");
      kd = f && !o && !(e && mdl[11][5]);
      dd = f && !kd;
      pv = t;
      if (t) begin
        pc = 2'(mdl[12 + p[2]] >> (2 * p[1:0]));
        have = 1;
      end
    end
  endtask

  task automatic period(input logic sp, input int exp);
    int n;
    @(posedge clk_sys);
    port_speed_100 <= sp;
    repeat (2) begin
      @(negedge clk_sys);
      for (n = 1; n < 200 && !storm_period_tick; n++) @(negedge clk_sys);
    end
    if (n < 200) chk(n, exp, "period");
    else hang("tick");
  endtask

  initial begin
    logic [7:0] d;
    for (int r = 0; r < 2; r++) begin
      do_reset();
      for (int i = 7; i < 14; i++) rreg(i);
      outs();
      policy();
    end
    foreach (bad[k]) begin
      axi(1'b0, bad[k]);
      chk(resp, RESP_SLVERR, "bad rresp");
      chk(rd, 32'h00000000, "bad rdata");
      axi(1'b1, bad[k], 8'hFF, 1'b1);
      chk(resp, RESP_SLVERR, "bad bresp");
    end
    axi(1'b1, 8'h1C, 8'h5A, 1'b0);
    chk(resp, RESP_OKAY, "nostrb bresp");
    for (int i = 7; i < 14; i++) rreg(i);
    for (int ps = 0; ps < 4; ps++) begin
      @(posedge clk_sys);
      storm_rate_high <= 3'($random(seed));
      // Factory test registers are never written by software
      wreg(7, 8'($random(seed)));
      wreg(12, 8'($random(seed)));
      wreg(13, 8'($random(seed)));
      d = 8'($random(seed));
      d[4] = 1'b0;
      d[5] = ps[0];
      d[3:2] = 2'(ps);
      wreg(11, d);
      for (int i = 7; i < 14; i++) rreg(i);
      outs();
      policy();
    end
    period(1'b1, 20);
    period(1'b0, 50);
    period(1'b1, 20);
    end_of_test();
  end
endmodule
`default_nettype wire
